// ---- rtl/bsc_codec.sv ----
`timescale 1ns/1ps
`default_nettype none
module bsc_codec #(
   parameter int unsigned CYC_PER_MS = bsc_pkg::CYC_PER_MS,
   parameter int unsigned NB         = 8
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   output logic             frame_start_o,
   output logic      [15:0] seed_o,
   output logic      [10:0] root_o,
   output logic      [7:0]  sym1_bits_o,
   output logic      [12:0] interval_ms_o
);
   localparam int unsigned PW = $clog2(CYC_PER_MS);
   localparam logic [PW-1:0] PRESC_LAST = PW'(CYC_PER_MS - 1);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      for (int b = 0; b < 4; b++) begin
         merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
      end
   endfunction : merge

   // a request is legal only with a seeded minor and defined field values
   function automatic logic cfg_ok(input logic [31:0] c);
      logic [3:0] mn;
      logic [2:0] ns;
      mn = c[bsc_pkg::CTRL_MINOR_LSB +: 4];
      ns = c[bsc_pkg::CTRL_NSYM_LSB +: 3];
      cfg_ok = (mn < bsc_pkg::NUM_MINOR)
            && (c[bsc_pkg::CTRL_CODE_LSB +: 5] != bsc_pkg::CODE_FORBID)
            && (c[bsc_pkg::CTRL_BW_LSB +: 2] != bsc_pkg::BW_ABOVE8)
            && (ns >= bsc_pkg::NSYM_MIN)
            && ((mn != 4'h0) || (ns == bsc_pkg::NSYM_V0));
   endfunction : cfg_ok

   // bus slave
   logic        ack_ff, nxt_ack;
   logic [31:0] dat_ff, nxt_dat;
   logic        wr_go;
   logic [31:0] rd_val;

   // configuration and result state
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [15:0] sym23_ff, nxt_sym23;
   logic [bsc_pkg::IRQ_W-1:0] ist_ff, nxt_ist, imask_ff, nxt_imask, ev;
   logic        irq_ff, nxt_irq;
   logic [10:0] shift_ff [3];
   logic [10:0] nxt_shift [3];
   logic        fs_ff, nxt_fs;
   logic [15:0] seed_ff, nxt_seed;
   logic [10:0] root_ff, nxt_root;
   logic [7:0]  s1_ff, nxt_s1;
   logic [12:0] ival_ff, nxt_ival;

   // sequencer
   bsc_pkg::bsc_state_e st_ff, nxt_st;
   logic [1:0]  cnt_ff, nxt_cnt;

   // interval timer
   logic [PW-1:0] presc_ff, nxt_presc;
   logic [12:0]   ms_ff, nxt_ms;
   logic          run_ff, nxt_run;
   logic          arm_ff, nxt_arm;
   logic [3:0]    pmin_ff, nxt_pmin;
   logic [12:0]   pt_ff, nxt_pt;
   logic [12:0]   ptn_ff, nxt_ptn;

   logic [31:0] new_ctrl, sym_mrg;
   logic        go, early, accept;
   logic [4:0]  code;

   bsc_shift_if sif ();

   bsc_gray_shift #(.NB(NB)) u_gray (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .sb    (sif.enc)
   );

   // writes land on the edge the master sees ack
   assign wr_go    = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
   assign new_ctrl = merge(ctrl_ff, wb_dat_i, wb_sel_i);
   assign sym_mrg  = merge({16'h0000, sym23_ff}, wb_dat_i, wb_sel_i);
   assign go       = wr_go && (wb_adr_i == bsc_pkg::ADR_CTRL)
                     && wb_sel_i[3] && wb_dat_i[bsc_pkg::CTRL_GO_BIT];
   assign code     = new_ctrl[bsc_pkg::CTRL_CODE_LSB +: 5];
   // a same-version start before the signaled interval would break the promise
   assign early    = run_ff && (pmin_ff == new_ctrl[bsc_pkg::CTRL_MINOR_LSB +: 4])
                     && (ms_ff < pt_ff);
   assign accept   = go && (st_ff == bsc_pkg::ST_IDLE) && cfg_ok(new_ctrl) && !early;

   always_comb begin
      case (wb_adr_i)
         bsc_pkg::ADR_CTRL:     rd_val = {1'b0, ctrl_ff[30:0]};
         bsc_pkg::ADR_SYM23:    rd_val = {16'h0000, sym23_ff};
         bsc_pkg::ADR_STAT:     rd_val = {14'h0000, ms_ff, 2'h0, arm_ff,
                                          (ms_ff >= pt_ff) && run_ff,
                                          st_ff != bsc_pkg::ST_IDLE};
         bsc_pkg::ADR_IVAL:     rd_val = {19'h00000, ival_ff};
         bsc_pkg::ADR_SHIFT1:   rd_val = {21'h000000, shift_ff[0]};
         bsc_pkg::ADR_SHIFT2:   rd_val = {21'h000000, shift_ff[1]};
         bsc_pkg::ADR_SHIFT3:   rd_val = {21'h000000, shift_ff[2]};
         bsc_pkg::ADR_IRQ_STAT: rd_val = {28'h0000000, ist_ff};
         bsc_pkg::ADR_IRQ_MASK: rd_val = {28'h0000000, imask_ff};
         default:               rd_val = 32'h0000_0000;
      endcase
   end

   always_comb begin
      nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
      nxt_dat = nxt_ack ? rd_val : dat_ff;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= '0;
      end else begin
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
      end
   end

   // register file and interrupt
   always_comb begin
      nxt_ctrl  = ctrl_ff;
      nxt_sym23 = sym23_ff;
      nxt_imask = imask_ff;
      ev        = '0;
      ev[bsc_pkg::IRQ_REJECT] = go && !accept;
      ev[bsc_pkg::IRQ_EARLY]  = go && early;
      ev[bsc_pkg::IRQ_DONE]   = sif.rsp && (sif.rsp_idx == 2'h2);
      ev[bsc_pkg::IRQ_LATE]   = run_ff && arm_ff && (ms_ff >= ptn_ff);
      nxt_ist = ist_ff;
      if (wr_go) begin
         case (wb_adr_i)
            bsc_pkg::ADR_CTRL:     nxt_ctrl  = {1'b0, new_ctrl[30:0]};
            bsc_pkg::ADR_SYM23:    nxt_sym23 = sym_mrg[15:0];
            bsc_pkg::ADR_IRQ_MASK: nxt_imask = wb_sel_i[0] ? wb_dat_i[bsc_pkg::IRQ_W-1:0]
                                                           : imask_ff;
            bsc_pkg::ADR_IRQ_STAT: nxt_ist   = wb_sel_i[0]
                                     ? ist_ff & ~wb_dat_i[bsc_pkg::IRQ_W-1:0] : ist_ff;
            default:               nxt_ctrl  = ctrl_ff;
         endcase
      end
      // set wins over a simultaneous clear
      nxt_ist = nxt_ist | ev;
      nxt_irq = |(nxt_ist & nxt_imask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff  <= bsc_pkg::CTRL_RST;
         sym23_ff <= '0;
         imask_ff <= '0;
         ist_ff   <= '0;
         irq_ff   <= 1'b0;
      end else begin
         ctrl_ff  <= nxt_ctrl;
         sym23_ff <= nxt_sym23;
         imask_ff <= nxt_imask;
         ist_ff   <= nxt_ist;
         irq_ff   <= nxt_irq;
      end
   end

   // frame outputs load together with the start pulse
   always_comb begin
      nxt_fs   = accept;
      nxt_seed = seed_ff;
      nxt_root = root_ff;
      nxt_s1   = s1_ff;
      nxt_ival = ival_ff;
      if (accept) begin
         nxt_seed = bsc_pkg::seed_of(new_ctrl[bsc_pkg::CTRL_MINOR_LSB +: 3]);
         nxt_root = bsc_pkg::ZC_ROOT_V0;
         nxt_s1   = {new_ctrl[bsc_pkg::CTRL_WAKE_LSB + 1],
                     code, new_ctrl[bsc_pkg::CTRL_BW_LSB +: 2]};
         nxt_ival = bsc_pkg::interval_ms(code);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fs_ff   <= 1'b0;
         seed_ff <= '0;
         root_ff <= '0;
         s1_ff   <= '0;
         ival_ff <= '0;
      end else begin
         fs_ff   <= nxt_fs;
         seed_ff <= nxt_seed;
         root_ff <= nxt_root;
         s1_ff   <= nxt_s1;
         ival_ff <= nxt_ival;
      end
   end

   // sequencer: one symbol per cycle through the gray mapper
   always_comb begin
      nxt_st    = st_ff;
      nxt_cnt   = cnt_ff;
      sif.req   = 1'b0;
      sif.idx   = cnt_ff;
      case (cnt_ff)
         2'h0:    sif.bits = s1_ff;
         2'h1:    sif.bits = sym23_ff[7:0];
         default: sif.bits = sym23_ff[15:8];
      endcase
      for (int i = 0; i < 3; i++) begin
         nxt_shift[i] = (sif.rsp && (sif.rsp_idx == 2'(i))) ? sif.shift : shift_ff[i];
      end
      case (st_ff)
         bsc_pkg::ST_IDLE: begin
            nxt_cnt = 2'h0;
            if (accept) begin
               nxt_st = bsc_pkg::ST_ISSUE;
            end
         end
         bsc_pkg::ST_ISSUE: begin
            sif.req = 1'b1;
            nxt_cnt = cnt_ff + 2'h1;
            if (cnt_ff == 2'h2) begin
               nxt_st = bsc_pkg::ST_WAIT;
            end
         end
         bsc_pkg::ST_WAIT: begin
            if (sif.rsp && (sif.rsp_idx == 2'h2)) begin
               nxt_st = bsc_pkg::ST_IDLE;
            end
         end
         default: nxt_st = bsc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff  <= bsc_pkg::ST_IDLE;
         cnt_ff <= '0;
         for (int i = 0; i < 3; i++) begin
            shift_ff[i] <= '0;
         end
      end else begin
         st_ff  <= nxt_st;
         cnt_ff <= nxt_cnt;
         for (int i = 0; i < 3; i++) begin
            shift_ff[i] <= nxt_shift[i];
         end
      end
   end

   // interval timer; saturates so a long gap never wraps into the window
   always_comb begin
      nxt_presc = presc_ff;
      nxt_ms    = ms_ff;
      nxt_run   = run_ff;
      nxt_arm   = arm_ff && !ev[bsc_pkg::IRQ_LATE];
      nxt_pmin  = pmin_ff;
      nxt_pt    = pt_ff;
      nxt_ptn   = ptn_ff;
      if (accept) begin
         nxt_presc = '0;
         nxt_ms    = '0;
         nxt_run   = 1'b1;
         nxt_arm   = 1'b1;
         nxt_pmin  = new_ctrl[bsc_pkg::CTRL_MINOR_LSB +: 4];
         nxt_pt    = bsc_pkg::interval_ms(code);
         nxt_ptn   = bsc_pkg::interval_ms(code + 5'h01);
      end else if (run_ff) begin
         nxt_presc = (presc_ff == PRESC_LAST) ? '0 : presc_ff + 1'b1;
         if ((presc_ff == PRESC_LAST) && (ms_ff != '1)) begin
            nxt_ms = ms_ff + 13'h0001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_ff <= '0;
         ms_ff    <= '0;
         run_ff   <= 1'b0;
         arm_ff   <= 1'b0;
         pmin_ff  <= '0;
         pt_ff    <= '0;
         ptn_ff   <= '0;
      end else begin
         presc_ff <= nxt_presc;
         ms_ff    <= nxt_ms;
         run_ff   <= nxt_run;
         arm_ff   <= nxt_arm;
         pmin_ff  <= nxt_pmin;
         pt_ff    <= nxt_pt;
         ptn_ff   <= nxt_ptn;
      end
   end

   assign wb_ack_o      = ack_ff;
   assign wb_dat_o      = dat_ff;
   assign irq_o         = irq_ff;
   assign frame_start_o = fs_ff;
   assign seed_o        = seed_ff;
   assign root_o        = root_ff;
   assign sym1_bits_o   = s1_ff;
   assign interval_ms_o = ival_ff;

   root_major0_a: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_start_o |-> root_o == 11'h089)
      else $error("root not 137 at frame start");

   seed_minor_a: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_start_o |-> seed_o == bsc_pkg::seed_of(ctrl_ff[2:0]))
      else $error("seed does not match minor version");

   nsym_min_a: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_start_o |-> ctrl_ff[bsc_pkg::CTRL_NSYM_LSB +: 3] >= 3'h4)
      else $error("fewer than four symbols");

   nsym_minor0_a: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_start_o && (ctrl_ff[3:0] == 4'h0)
      |-> ctrl_ff[bsc_pkg::CTRL_NSYM_LSB +: 3] == 3'h4)
      else $error("minor zero without exactly four symbols");

   sym1_layout_a: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_start_o |-> sym1_bits_o == {ctrl_ff[5], ctrl_ff[10:6], ctrl_ff[12:11]})
      else $error("first symbol field layout wrong");

   code_forbid_a: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_start_o |-> (sym1_bits_o[6:2] != 5'h1f) && (sym1_bits_o[1:0] != 2'h3))
      else $error("forbidden interval or bandwidth sent");

   ival_table_a: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_start_o && (sym1_bits_o[6:2] == 5'h0a) |-> interval_ms_o == 13'h02bc)
      else $error("code 10 not mapped to 700 ms");

   ival_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_start_o && (sym1_bits_o[6:2] == 5'h19) |-> interval_ms_o == 13'h0ce4)
      else $error("code 25 not mapped to 3300 ms");

   minor_seeded_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go && (new_ctrl[3:0] >= 4'h8) |=> !frame_start_o && ist_ff[1])
      else $error("unseeded minor version started");

   early_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_start_o && $past(run_ff) && (ctrl_ff[3:0] == $past(pmin_ff))
      |-> $past(ms_ff) >= $past(pt_ff))
      else $error("same-version start before signaled interval");

endmodule : bsc_codec
`default_nettype wire

// ---- rtl/bsc_pkg.sv ----
package bsc_pkg;

   localparam int unsigned SHIFT_W = 11;
   localparam int unsigned BITS_W  = 8;
   localparam int unsigned MS_W    = 13;
   localparam int unsigned IRQ_W   = 4;

   // frequency-domain sequence root for major version zero
   localparam logic [SHIFT_W-1:0] ZC_ROOT_V0 = 11'h089;
   localparam logic [3:0]         NUM_MINOR  = 4'h8;
   localparam logic [2:0]         NSYM_MIN   = 3'h4;
   localparam logic [2:0]         NSYM_V0    = 3'h4;
   localparam logic [4:0]         CODE_FORBID = 5'h1f;
   localparam logic [1:0]         BW_ABOVE8  = 2'h3;

   // register byte addresses
   localparam logic [7:0] ADR_CTRL     = 8'h00;
   localparam logic [7:0] ADR_SYM23    = 8'h04;
   localparam logic [7:0] ADR_STAT     = 8'h08;
   localparam logic [7:0] ADR_IVAL     = 8'h0c;
   localparam logic [7:0] ADR_SHIFT1   = 8'h10;
   localparam logic [7:0] ADR_SHIFT2   = 8'h14;
   localparam logic [7:0] ADR_SHIFT3   = 8'h18;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h1c;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h20;

   // control word layout
   localparam int unsigned CTRL_MINOR_LSB = 0;
   localparam int unsigned CTRL_WAKE_LSB  = 4;
   localparam int unsigned CTRL_CODE_LSB  = 6;
   localparam int unsigned CTRL_BW_LSB    = 11;
   localparam int unsigned CTRL_NSYM_LSB  = 13;
   localparam int unsigned CTRL_GO_BIT    = 31;
   localparam logic [31:0] CTRL_RST       = 32'h0000_8000;

   localparam int unsigned IRQ_DONE   = 0;
   localparam int unsigned IRQ_REJECT = 1;
   localparam int unsigned IRQ_EARLY  = 2;
   localparam int unsigned IRQ_LATE   = 3;

   // millisecond tick from the 40 MHz clock
   localparam int unsigned MS_NS      = 1000000;
   localparam int unsigned CLK_NS     = 25;
   localparam int unsigned CYC_PER_MS = MS_NS / CLK_NS;

   localparam logic [MS_W-1:0] T_STEP0 = 13'h0032;
   localparam logic [MS_W-1:0] T_BASE0 = 13'h0032;
   localparam logic [MS_W-1:0] T_STEP1 = 13'h0064;
   localparam logic [MS_W-1:0] T_BASE1 = 13'h01f4;
   localparam logic [MS_W-1:0] T_STEP2 = 13'h00c8;
   localparam logic [MS_W-1:0] T_BASE2 = 13'h0514;
   localparam logic [MS_W-1:0] T_STEP3 = 13'h0190;
   localparam logic [MS_W-1:0] T_BASE3 = 13'h0b54;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ISSUE = 3'b010,
      ST_WAIT  = 3'b100
   } bsc_state_e;

   // code 31 yields 5700, used only as the upper window edge of code 30
   function automatic logic [MS_W-1:0] interval_ms(input logic [4:0] code);
      logic [MS_W-1:0] off;
      off = {10'h000, code[2:0]};
      case (code[4:3])
         2'h0:    interval_ms = T_STEP0 * off + T_BASE0;
         2'h1:    interval_ms = T_STEP1 * off + T_BASE1;
         2'h2:    interval_ms = T_STEP2 * off + T_BASE2;
         default: interval_ms = T_STEP3 * off + T_BASE3;
      endcase
   endfunction : interval_ms

   function automatic logic [15:0] seed_of(input logic [2:0] minor);
      case (minor)
         3'h0:    seed_of = 16'h019d;
         3'h1:    seed_of = 16'h00ed;
         3'h2:    seed_of = 16'h01e8;
         3'h3:    seed_of = 16'h00e8;
         3'h4:    seed_of = 16'h00fb;
         3'h5:    seed_of = 16'h0021;
         3'h6:    seed_of = 16'h0054;
         default: seed_of = 16'h00ec;
      endcase
   endfunction : seed_of

endpackage : bsc_pkg

// ---- rtl/bsc_shift_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface bsc_shift_if;
   logic                          req;
   logic [1:0]                    idx;
   logic [bsc_pkg::BITS_W-1:0]    bits;
   logic                          rsp;
   logic [1:0]                    rsp_idx;
   logic [bsc_pkg::SHIFT_W-1:0]   shift;

   modport enc (input req, input idx, input bits, output rsp, output rsp_idx, output shift);
   modport ctl (output req, output idx, output bits, input rsp, input rsp_idx, input shift);
endinterface : bsc_shift_if
`default_nettype wire

// ---- rtl/bsc_gray_shift.sv ----
`timescale 1ns/1ps
`default_nettype none
module bsc_gray_shift #(
   parameter int unsigned NB = 8
) (
   input  wire logic     clk_i,
   input  wire logic     rst_i,
   bsc_shift_if.enc      sb
);
   logic [bsc_pkg::SHIFT_W-1:0] shift_ff;
   logic [bsc_pkg::SHIFT_W-1:0] nxt_shift;
   logic [1:0]                  idx_ff;
   logic                        rsp_ff;

   // prefix xor of the bits, msb first, then a single one, then zeros
   always_comb begin
      logic acc;
      acc       = 1'b0;
      nxt_shift = '0;
      for (int k = 0; k < int'(bsc_pkg::SHIFT_W); k++) begin
         if (k < int'(NB)) begin
            acc = acc ^ sb.bits[int'(bsc_pkg::BITS_W) - 1 - k];
            nxt_shift[int'(bsc_pkg::SHIFT_W) - 1 - k] = acc;
         end else if (k == int'(NB)) begin
            nxt_shift[int'(bsc_pkg::SHIFT_W) - 1 - k] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_ff <= '0;
         idx_ff   <= '0;
         rsp_ff   <= 1'b0;
      end else begin
         shift_ff <= sb.req ? nxt_shift : shift_ff;
         idx_ff   <= sb.req ? sb.idx : idx_ff;
         rsp_ff   <= sb.req;
      end
   end

   assign sb.shift   = shift_ff;
   assign sb.rsp_idx = idx_ff;
   assign sb.rsp     = rsp_ff;

   shift_marker_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sb.rsp |-> (sb.shift[int'(bsc_pkg::SHIFT_W) - 1 - int'(NB)] == 1'b1)
                 && (sb.shift[int'(bsc_pkg::SHIFT_W) - 1] == $past(sb.bits[7])))
      else $error("shift marker or leading bit wrong");

endmodule : bsc_gray_shift
`default_nettype wire

// ---- tb/bsc_rx_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bsc_rx_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        frame_start_i,
   input  wire logic [7:0]  bits_i,
   input  wire logic [10:0] root_i,
   output logic      [7:0]  got_o,
   output logic      [7:0]  drop_o,
   output logic      [7:0]  bits_o
);
   // undefined content is counted and dropped, never decoded
   wire logic bad = (bits_i[6:2] == 5'h1f) || (bits_i[1:0] == 2'h3)
                    || (root_i != 11'h089);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         got_o  <= 8'h00;
         drop_o <= 8'h00;
         bits_o <= 8'h00;
      end else if (frame_start_i && bad) begin
         drop_o <= drop_o + 8'h01;
      end else if (frame_start_i) begin
         got_o  <= got_o + 8'h01;
         bits_o <= bits_i;
      end
   end
endmodule : bsc_rx_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [15:0] SEEDS [8] = '{16'h019d, 16'h00ed, 16'h01e8, 16'h00e8,
                                        16'h00fb, 16'h0021, 16'h0054, 16'h00ec};
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] wdat  = 32'h0;
   logic [31:0] rdat, q;
   logic        ack, irq, fs;
   logic [15:0] seed;
   logic [10:0] root;
   logic [7:0]  s1bits, got, drop, rxbits, eb;
   logic [12:0] ivl;
   logic [31:0] bad [5];
   int          num_errors = 0;
   int          checks = 0;
   int          cyc_cnt = 0;

   always #12.5 clk_i = ~clk_i;

   bsc_codec #(.CYC_PER_MS(4)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .frame_start_o(fs),
      .seed_o(seed), .root_o(root), .sym1_bits_o(s1bits), .interval_ms_o(ivl));

   bsc_rx_model i_rx (
      .clk_i(clk_i), .rst_i(rst_i), .frame_start_i(fs), .bits_i(s1bits),
      .root_i(root), .got_o(got), .drop_o(drop), .bits_o(rxbits));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // classic cycle: hold everything until ack is sampled, then idle one cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= 4'hf;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic wait_done();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      chk("done irq", 32'h1, irq);
      wb(1'b1, bsc_pkg::ADR_IRQ_STAT, 32'h1);
      @(posedge clk_i);
      chk("irq cleared", 32'h0, irq);
   endtask : wait_done

   function automatic logic [31:0] ctrl(input int mn, input int al, input int cd,
                                        input int bw, input int ns);
      return {1'b1, 15'h0000, 3'(ns), 2'(bw), 5'(cd), 2'(al), 4'(mn)};
   endfunction : ctrl

   function automatic logic [12:0] exp_ms(input int x);
      if (x < 8) return 13'(50 * x + 50);
      if (x < 16) return 13'(100 * (x - 8) + 500);
      if (x < 24) return 13'(200 * (x - 16) + 1300);
      return 13'(400 * (x - 24) + 2900);
   endfunction : exp_ms

   function automatic logic [10:0] gray(input logic [7:0] b);
      logic [10:0] m;
      logic        acc;
      m = 11'h004;
      acc = 1'b0;
      for (int k = 0; k < 8; k++) begin
         acc = acc ^ b[7-k];
         m[10-k] = acc;
      end
      return m;
   endfunction : gray

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   // whole run needs well under two thousand cycles
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         num_errors++;
         final_report();
      end
   end

   initial begin
      bad[0] = ctrl(8, 0, 0, 0, 4);
      bad[1] = ctrl(2, 0, 31, 0, 4);
      bad[2] = ctrl(3, 0, 1, 3, 4);
      bad[3] = ctrl(0, 0, 1, 0, 5);
      bad[4] = ctrl(1, 0, 1, 0, 3);
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, bsc_pkg::ADR_CTRL, 32'h0);
      chk("ctrl reset", 32'h0000_8000, q);
      wb(1'b1, 8'h3c, 32'hffff_ffff);
      wb(1'b0, 8'h3c, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1'b1, bsc_pkg::ADR_IRQ_MASK, 32'h1);
      wb(1'b0, bsc_pkg::ADR_IRQ_MASK, 32'h0);
      chk("mask", 32'h1, q);
      $display("test registers done");
      // minors rotate so no start ever follows one of its own version
      for (int c = 0; c < 31; c++) begin
         eb = {c[1], 5'(c), 2'(c % 3)};
         wb(1'b1, bsc_pkg::ADR_SYM23, {16'h0000, 8'(255 - c), 8'(7 * c)});
         wb(1'b1, bsc_pkg::ADR_CTRL, ctrl(c % 8, c % 4, c, c % 3, 4 + c % 4));
         wait_done();
         chk("seed", SEEDS[c % 8], seed);
         chk("root", 11'h089, root);
         chk("sym1 bits", eb, s1bits);
         chk("rx bits", eb, rxbits);
         chk("interval", exp_ms(c), ivl);
         wb(1'b0, bsc_pkg::ADR_SHIFT1, 32'h0);
         chk("shift1", gray(eb), q);
         wb(1'b0, bsc_pkg::ADR_SHIFT2, 32'h0);
         chk("shift2", gray(8'(7 * c)), q);
         wb(1'b0, bsc_pkg::ADR_SHIFT3, 32'h0);
         chk("shift3", gray(8'(255 - c)), q);
         wb(1'b0, bsc_pkg::ADR_IVAL, 32'h0);
         chk("ival reg", exp_ms(c), q);
      end
      chk("rx frames", 8'h1f, got);
      chk("rx drops", 8'h00, drop);
      $display("test accepts done");
      for (int i = 0; i < 5; i++) begin
         wb(1'b1, bsc_pkg::ADR_CTRL, bad[i]);
         wb(1'b0, bsc_pkg::ADR_IRQ_STAT, 32'h0);
         chk("reject stat", 32'h2, q);
         chk("masked irq", 32'h0, irq);
         wb(1'b1, bsc_pkg::ADR_IRQ_STAT, 32'hf);
      end
      $display("test rejects done");
      wb(1'b1, bsc_pkg::ADR_CTRL, ctrl(6, 0, 0, 0, 4));
      wb(1'b0, bsc_pkg::ADR_IRQ_STAT, 32'h0);
      chk("early stat", 32'h6, q);
      chk("no frame", 8'h1f, got);
      $display("test early done");
      wb(1'b1, bsc_pkg::ADR_IRQ_STAT, 32'hf);
      wb(1'b1, bsc_pkg::ADR_IRQ_MASK, 32'h9);
      wb(1'b1, bsc_pkg::ADR_CTRL, ctrl(7, 0, 0, 0, 4));
      // second go lands while the first frame is still issuing
      wb(1'b1, bsc_pkg::ADR_CTRL, ctrl(5, 0, 0, 0, 4));
      wait_done();
      wb(1'b0, bsc_pkg::ADR_IRQ_STAT, 32'h0);
      chk("busy reject", 32'h2, q);
      // code 0 closes its window at 100 ms, 400 cycles at the bench rate
      repeat (420) @(posedge clk_i);
      chk("late irq", 32'h1, irq);
      wb(1'b0, bsc_pkg::ADR_IRQ_STAT, 32'h0);
      chk("late stat", 32'ha, q);
      wb(1'b0, bsc_pkg::ADR_STAT, 32'h0);
      chk("window stat", 32'h2, q & 32'h7);
      wb(1'b1, bsc_pkg::ADR_IRQ_STAT, 32'hf);
      wb(1'b1, bsc_pkg::ADR_CTRL, ctrl(7, 0, 0, 0, 4));
      wait_done();
      chk("same version start", 8'h21, got);
      $display("test window done");
      final_report();
   end
endmodule : tb_top
`default_nettype wire
